// ### rtl/pbc_dev_end.sv
// Device end of the bus control link: single-word initiator plus configuration target.
// Assumes every link input is synchronous to clk_i; partner keeps its own protocol rules.
`timescale 1ns/1ns
`include "pbc_defs.svh"
module pbc_dev_end
  import pbc_pkg::*;
#(
  parameter int TIMEOUT = 5  // Clocks waited for device select
) (
  input  wire logic      clk_i,
  input  wire logic      arst_n_i,
  input  wire logic      en_i,          // Clock enable; low freezes all state
  pbc_link_if.dev        bus,
  input  wire logic      go_i,          // Start one initiator transfer
  input  wire pbc_cmd_t  go_cmd_i,      // Bus command for that transfer
  input  wire pbc_word_t go_addr_i,     // Address
  input  wire pbc_word_t go_data_i,     // Write data
  input  wire pbc_cmd_t  go_be_n_i,     // Byte enables, active low
  input  wire logic      go_lock_i,     // Hold lock for this transfer
  input  wire logic      pin_mode_i,    // Shared pin config setting: 1 selects lock
  input  wire logic      gpio_out_i,    // General-purpose drive value
  input  wire logic      gpio_oe_i,     // General-purpose drive enable
  input  wire logic      sys_err_i,     // Internal system error event
  input  wire logic      sec_par_err_i, // Secondary side address parity error event
  input  wire logic      bridge_serr_en_i, // Bridge control system-error enable
  output logic           busy_o,        // Initiator transfer in flight
  output logic           done_o,        // One-cycle pulse: transfer completed
  output logic           abort_o,       // One-cycle pulse: initiator abort
  output logic           stopped_o,     // One-cycle pulse: target stopped us
  output pbc_word_t      rdata_o,       // Read data of last transfer
  output logic [`PBC_CMD_W-1:0] cmd_reg_o, // Command word
  output logic           gpio_in_o      // Sampled shared pin level
);
  // Wait counter is three bits wide, so longer timeouts cannot be served
  if (TIMEOUT < 1 || TIMEOUT > 7) begin : g_bad_timeout
    $error("TIMEOUT out of range");
  end

  // Even parity of a word and nibble; used for both drive and check paths
  function automatic logic even_par(input pbc_word_t w, input pbc_cmd_t c);
    even_par = ^{w, c};
  endfunction : even_par

  typedef enum logic [4:0] {
    M_IDLE = 5'h01, M_REQ = 5'h02, M_ADDR = 5'h04, M_DATA = 5'h08, M_TURN = 5'h10
  } pbc_mst_e;
  typedef enum logic [2:0] {
    T_IDLE = 3'h1, T_DATA = 3'h2, T_TURN = 3'h4
  } pbc_tgt_e;

  pbc_mst_e  m_q, m_d;                  // Initiator state
  pbc_tgt_e  t_q, t_d;                  // Target state
  logic [2:0] wait_q, wait_d;           // Device select wait counter
  pbc_cmd_t  cmd_q, cmd_d;              // Latched command
  pbc_word_t addr_q, addr_d, wd_q, wd_d, rd_q, rd_d;
  pbc_cmd_t  be_q, be_d;
  logic      lk_q, lk_d;                // Lock asked for
  logic      tw_q, tw_d;                // Target access is a write
  logic [7:0] treg_q, treg_d;           // Config dword index being accessed
  logic [`PBC_CMD_W-1:0] creg_q, creg_d;// Command register (config dword 1 low)
  logic      pchk_q, pchk_d;            // Check parity on next clock
  pbc_word_t pw_q, pw_d;  pbc_cmd_t pc_q, pc_d;
  logic      par_q, par_d, paroe_q, paroe_d;
  logic      perr_q, perr_d, serr_q, serr_d;
  logic      done_q, done_d, abort_q, abort_d, stp_q, stp_d, gin_q, gin_d;
  logic      phase_ok;                  // Both readies sampled low

  assign phase_ok = ~bus.irdy_n & ~bus.trdy_n;

  // Next-state logic for initiator, target, parity and error pulses
  always_comb begin
    m_d = m_q; t_d = t_q; wait_d = wait_q; cmd_d = cmd_q; addr_d = addr_q;
    wd_d = wd_q; rd_d = rd_q; be_d = be_q; lk_d = lk_q; tw_d = tw_q; treg_d = treg_q;
    creg_d = creg_q; done_d = 1'b0; abort_d = 1'b0; stp_d = 1'b0;
    pchk_d = 1'b0; pw_d = bus.ad; pc_d = bus.cbe_n;
    paroe_d = 1'b0; par_d = 1'b0;
    gin_d = bus.lock_n;
    unique case (m_q)
      M_IDLE: if (go_i) begin         // Latch job, then ask for the bus
        m_d = M_REQ; cmd_d = go_cmd_i; addr_d = go_addr_i; wd_d = go_data_i;
        be_d = go_be_n_i; lk_d = go_lock_i & pin_mode_i;
      end
      // Unrequested parking grant is simply ignored in idle
      M_REQ: if (~bus.gnt_n && bus.frame_n && bus.irdy_n) begin
        m_d = M_ADDR; wait_d = '0;
      end
      M_ADDR: m_d = M_DATA;           // One address clock, command on nibble
      M_DATA: begin
        wait_d = wait_q + 3'h1;
        if (phase_ok || ~bus.stop_n) begin
          if (phase_ok) rd_d = bus.ad;
          done_d = phase_ok; stp_d = ~phase_ok; m_d = M_TURN;
        end else if (bus.devsel_n && wait_q >= 3'(TIMEOUT - 1)) begin
          abort_d = 1'b1; m_d = M_TURN;
        end
      end
      M_TURN: m_d = M_IDLE;
      default: m_d = M_IDLE;
    endcase
    // Parity lags the phase it covers by one clock
    if (m_q == M_ADDR || (m_q == M_DATA && cmd_q[0])) begin
      paroe_d = 1'b1; par_d = even_par(bus.ad, bus.cbe_n);
    end
    unique case (t_q)
      T_IDLE: if (!bus.frame_n && m_q != M_DATA && m_q != M_ADDR && bus.idsel
                  && (bus.cbe_n == `PBC_BUS_CFG_READ || bus.cbe_n == `PBC_BUS_CFG_WRITE)) begin
        t_d = T_DATA; tw_d = bus.cbe_n[0]; treg_d = bus.ad[9:2]; pchk_d = 1'b1;
      end
      T_DATA: if (~bus.irdy_n) begin  // Single-phase target: answer now, disconnect bursts
        if (tw_q && treg_q == 8'h01 && ~bus.cbe_n[0]) creg_d[7:0] = bus.ad[7:0];
        if (tw_q && treg_q == 8'h01 && ~bus.cbe_n[1]) creg_d[15:8] = bus.ad[15:8];
        if (!tw_q && treg_q == 8'h01) rd_d = rd_q;
        t_d = T_TURN; pchk_d = tw_q;
      end
      T_TURN: t_d = T_IDLE;
      default: t_d = T_IDLE;
    endcase
    if (t_q == T_IDLE && t_d == T_IDLE) pchk_d = 1'b0;
    // Parity compare only when enabled by command bit six
    perr_d = pchk_q && creg_q[`PBC_CMD_PERR_BIT] && (even_par(pw_q, pc_q) != bus.par);
    serr_d = (sys_err_i && creg_q[`PBC_CMD_SERR_BIT])
           || (sec_par_err_i && bridge_serr_en_i);
  end

  // Register all state; clock enable freezes everything
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      m_q <= M_IDLE; t_q <= T_IDLE; wait_q <= '0; cmd_q <= '0; addr_q <= '0; wd_q <= '0;
      rd_q <= '0; be_q <= 4'hF; lk_q <= 1'b0; tw_q <= 1'b0; treg_q <= '0;
      creg_q <= `PBC_CMD_RST; pchk_q <= 1'b0; pw_q <= '0; pc_q <= '0; par_q <= 1'b0;
      paroe_q <= 1'b0; perr_q <= 1'b0; serr_q <= 1'b0; done_q <= 1'b0; abort_q <= 1'b0;
      stp_q <= 1'b0; gin_q <= 1'b1;
    end else if (en_i) begin
      m_q <= m_d; t_q <= t_d; wait_q <= wait_d; cmd_q <= cmd_d; addr_q <= addr_d;
      wd_q <= wd_d; rd_q <= rd_d; be_q <= be_d; lk_q <= lk_d; tw_q <= tw_d;
      treg_q <= treg_d; creg_q <= creg_d; pchk_q <= pchk_d; pw_q <= pw_d; pc_q <= pc_d;
      par_q <= par_d; paroe_q <= paroe_d; perr_q <= perr_d; serr_q <= serr_d;
      done_q <= done_d; abort_q <= abort_d; stp_q <= stp_d; gin_q <= gin_d;
    end
  end

  // Pin drive derives from state registers, except the shared pin, which also follows pin_mode_i, gpio_oe_i and gpio_out_i
  always_comb begin
    bus.req_n        = ~(m_q == M_REQ);
    bus.frame_dev_oe = (m_q == M_ADDR || m_q == M_DATA || m_q == M_TURN);
    bus.frame_dev_n  = ~(m_q == M_ADDR);                      // single phase: last at once
    bus.irdy_dev_oe  = (m_q == M_DATA || m_q == M_TURN);
    bus.irdy_dev_n   = ~(m_q == M_DATA);
    bus.ad_dev_oe    = (m_q == M_ADDR) || (m_q == M_DATA && cmd_q[0])
                       || (t_q == T_DATA && !tw_q);
    bus.ad_dev       = (m_q == M_ADDR) ? addr_q : (m_q == M_DATA) ? wd_q :
                       {16'h0000, creg_q};
    bus.cbe_dev_oe   = (m_q == M_ADDR || m_q == M_DATA);
    bus.cbe_dev_n    = (m_q == M_ADDR) ? cmd_q : be_q;
    bus.par_dev_oe   = paroe_q;
    bus.par_dev      = par_q;
    bus.devsel_dev_oe = (t_q != T_IDLE);
    bus.devsel_dev_n  = ~(t_q == T_DATA);
    bus.trdy_dev_oe   = (t_q != T_IDLE);
    bus.trdy_dev_n    = ~(t_q == T_DATA);
    bus.stop_dev_oe   = (t_q != T_IDLE);
    bus.stop_dev_n    = ~(t_q == T_DATA);                     // disconnect with data
    bus.perr_dev_oe   = perr_q;
    bus.perr_dev_n    = ~perr_q;
    bus.serr_dev_oe   = serr_q;
    bus.serr_dev_n    = ~serr_q;
    // Shared pin: general-purpose per gpio_oe_i and gpio_out_i, lock when configured
    bus.lock_dev_oe   = pin_mode_i ? (lk_q && m_q != M_IDLE) : gpio_oe_i;
    bus.lock_dev_n    = pin_mode_i ? ~(m_q == M_DATA || m_q == M_TURN) : gpio_out_i;
  end

  assign busy_o    = (m_q != M_IDLE);
  assign done_o    = done_q;
  assign abort_o   = abort_q;
  assign stopped_o = stp_q;
  assign rdata_o   = rd_q;
  assign cmd_reg_o = creg_q;
  assign gpio_in_o = gin_q;
endmodule : pbc_dev_end

// ### rtl/pbc_defs.svh
// Shared constants for the bus control ends: timing, field positions, reset values.
// Assumes inclusion by bare name from the package and both ends.
`ifndef PBC_DEFS_SVH
`define PBC_DEFS_SVH
`define PBC_DEVSEL_TIMEOUT   3'h5   // Clocks after frame start before initiator abort
`define PBC_CMD_PERR_BIT     6      // Parity-error response enable in command word
`define PBC_CMD_SERR_BIT     8      // System-error report enable in command word
`define PBC_CMD_W            16     // Command word width
`define PBC_CMD_RST          16'h0000
`define PBC_BUS_CFG_READ     4'hA   // Configuration read command code
`define PBC_BUS_CFG_WRITE    4'hB   // Configuration write command code
`define PBC_BUS_MEM_READ     4'h6
`define PBC_BUS_MEM_WRITE    4'h7
`define PBC_PIN_MODE_GPIO    1'b0   // Shared pin reset mode
`define PBC_PIN_MODE_LOCK    1'b1
`endif

// ### rtl/pbc_pkg.sv
// Types shared by both ends of the bus control link.
// Assumes pbc_defs.svh is on the include path.
`include "pbc_defs.svh"
package pbc_pkg;
  typedef logic [3:0] pbc_cmd_t;  // Bus command / byte enable nibble
  typedef logic [31:0] pbc_word_t; // Address/data word
endpackage : pbc_pkg

// ### rtl/pbc_link_if.sv
// Bus control wires between the device end and the host/arbiter end.
// Open-drain style pins resolve here from output enables; active-low lines read high idle.
`timescale 1ns/1ns
interface pbc_link_if;
  import pbc_pkg::*;
  // Initiator-driven lines (from whichever end owns the bus)
  logic      frame_dev_n, frame_dev_oe, frame_host_n, frame_host_oe;
  logic      irdy_dev_n,  irdy_dev_oe,  irdy_host_n,  irdy_host_oe;
  // Target-driven lines, then error lines and the shared lock pin
  logic      devsel_dev_n, devsel_dev_oe, devsel_host_n, devsel_host_oe;
  logic      trdy_dev_n,   trdy_dev_oe,   trdy_host_n,   trdy_host_oe;
  logic      stop_dev_n,   stop_dev_oe,   stop_host_n,   stop_host_oe;
  logic      perr_dev_n,   perr_dev_oe;
  logic      serr_dev_n,   serr_dev_oe;
  logic      lock_dev_n,   lock_dev_oe,   lock_host_n,   lock_host_oe;
  // Arbiter and select lines
  logic      req_n, gnt_n, idsel;
  // Data path carried for parity and decode
  pbc_word_t ad_dev, ad_host;
  logic      ad_dev_oe, ad_host_oe;
  pbc_cmd_t  cbe_dev_n, cbe_host_n;
  logic      cbe_dev_oe, cbe_host_oe;
  logic      par_dev, par_dev_oe, par_host, par_host_oe;
  // Resolved levels (control lines pull up, ad and par read zero when nobody drives)
  logic      frame_n, irdy_n, devsel_n, trdy_n, stop_n, perr_n, serr_n, lock_n, par;
  pbc_word_t ad;
  pbc_cmd_t  cbe_n;
  assign frame_n  = ~((frame_dev_oe & ~frame_dev_n) | (frame_host_oe & ~frame_host_n));
  assign irdy_n   = ~((irdy_dev_oe & ~irdy_dev_n) | (irdy_host_oe & ~irdy_host_n));
  assign devsel_n = ~((devsel_dev_oe & ~devsel_dev_n) | (devsel_host_oe & ~devsel_host_n));
  assign trdy_n   = ~((trdy_dev_oe & ~trdy_dev_n) | (trdy_host_oe & ~trdy_host_n));
  assign stop_n   = ~((stop_dev_oe & ~stop_dev_n) | (stop_host_oe & ~stop_host_n));
  assign perr_n   = ~(perr_dev_oe & ~perr_dev_n);
  assign serr_n   = ~(serr_dev_oe & ~serr_dev_n);
  assign lock_n   = ~((lock_dev_oe & ~lock_dev_n) | (lock_host_oe & ~lock_host_n));
  assign ad       = ad_dev_oe ? ad_dev : (ad_host_oe ? ad_host : '0);
  assign cbe_n    = cbe_dev_oe ? cbe_dev_n : (cbe_host_oe ? cbe_host_n : 4'hF);
  assign par      = par_dev_oe ? par_dev : (par_host_oe ? par_host : 1'b0);
  modport dev (
    output frame_dev_n, frame_dev_oe, irdy_dev_n, irdy_dev_oe,
    output devsel_dev_n, devsel_dev_oe, trdy_dev_n, trdy_dev_oe, stop_dev_n, stop_dev_oe,
    output perr_dev_n, perr_dev_oe, serr_dev_n, serr_dev_oe, lock_dev_n, lock_dev_oe,
    output req_n, ad_dev, ad_dev_oe, cbe_dev_n, cbe_dev_oe, par_dev, par_dev_oe,
    input  gnt_n, idsel, frame_n, irdy_n, devsel_n, trdy_n, stop_n, lock_n, ad, cbe_n, par
  );
  modport host (
    output frame_host_n, frame_host_oe, irdy_host_n, irdy_host_oe,
    output devsel_host_n, devsel_host_oe, trdy_host_n, trdy_host_oe,
    output stop_host_n, stop_host_oe, lock_host_n, lock_host_oe,
    output gnt_n, idsel, ad_host, ad_host_oe, cbe_host_n, cbe_host_oe, par_host, par_host_oe,
    input  req_n, frame_n, irdy_n, devsel_n, trdy_n, stop_n, perr_n, serr_n, lock_n, ad, cbe_n,
    input  par
  );
endinterface : pbc_link_if

// ### rtl/pbc_host_end.sv
// Host/arbiter end: grants the bus, issues single config cycles, answers as a memory target.
// Assumes link inputs synchronous to clk_i; device end keeps its own protocol rules.
`timescale 1ns/1ns
`include "pbc_defs.svh"
module pbc_host_end
  import pbc_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      arst_n_i,
  input  wire logic      en_i,        // Clock enable
  pbc_link_if.host       bus,
  input  wire logic      park_i,      // Park grant on the device with no request
  input  wire logic      cfg_go_i,    // Start configuration access
  input  wire logic      cfg_wr_i,    // 1 write, 0 read
  input  wire pbc_word_t cfg_addr_i,  // Config address
  input  wire pbc_word_t cfg_data_i,  // Config write data
  input  wire logic      claim_i,     // Answer device-initiated cycles as target
  output logic           cfg_done_o,  // One-cycle pulse
  output pbc_word_t      cfg_rdata_o, // Config read data
  output logic           perr_seen_o, // Parity error seen (level pulse copy)
  output logic           serr_seen_o  // System error seen
);
  typedef enum logic [3:0] {H_IDLE = 4'h1, H_ADDR = 4'h2, H_DATA = 4'h4, H_TURN = 4'h8}
    pbc_hst_e;
  pbc_hst_e  h_q, h_d;
  logic      wr_q, wr_d, tgt_q, tgt_d, gnt_q, gnt_d, dn_q, dn_d, pe_q, pe_d, se_q, se_d;
  pbc_word_t a_q, a_d, w_q, w_d, r_q, r_d;
  logic      par_q, par_d, poe_q, poe_d;

  // Next values: arbiter, initiator and simple target
  always_comb begin
    h_d = h_q; wr_d = wr_q; a_d = a_q; w_d = w_q; r_d = r_q; dn_d = 1'b0;
    gnt_d = (~bus.req_n | park_i) && h_q == H_IDLE && !cfg_go_i;
    tgt_d = claim_i && !bus.frame_n && h_q == H_IDLE && gnt_q ? 1'b1 :
            (tgt_q && !(~bus.irdy_n && ~bus.trdy_n) ? tgt_q : 1'b0);
    pe_d = ~bus.perr_n; se_d = ~bus.serr_n;
    unique case (h_q)
      H_IDLE: if (cfg_go_i && bus.frame_n && bus.irdy_n && !gnt_q) begin
        h_d = H_ADDR; wr_d = cfg_wr_i; a_d = cfg_addr_i; w_d = cfg_data_i;
      end
      H_ADDR: h_d = H_DATA;
      H_DATA: if ((~bus.irdy_n && ~bus.trdy_n) || ~bus.stop_n) begin
        r_d = bus.ad; dn_d = 1'b1; h_d = H_TURN;
      end
      H_TURN: h_d = H_IDLE;
      default: h_d = H_IDLE;
    endcase
    poe_d = (h_q == H_ADDR) || (h_q == H_DATA && wr_q);
    par_d = ^{bus.ad, bus.cbe_n};
  end

  // Registers only
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      h_q <= H_IDLE; wr_q <= 1'b0; a_q <= '0; w_q <= '0; r_q <= '0; dn_q <= 1'b0;
      gnt_q <= 1'b0; tgt_q <= 1'b0; pe_q <= 1'b0; se_q <= 1'b0; par_q <= 1'b0; poe_q <= 1'b0;
    end else if (en_i) begin
      h_q <= h_d; wr_q <= wr_d; a_q <= a_d; w_q <= w_d; r_q <= r_d; dn_q <= dn_d;
      gnt_q <= gnt_d; tgt_q <= tgt_d; pe_q <= pe_d; se_q <= se_d; par_q <= par_d;
      poe_q <= poe_d;
    end
  end

  // Pins from state; the ad enable also follows irdy while acting as target
  always_comb begin
    bus.gnt_n         = ~gnt_q;
    bus.idsel         = (h_q == H_ADDR);
    bus.frame_host_oe = (h_q != H_IDLE);
    bus.frame_host_n  = ~(h_q == H_ADDR);
    bus.irdy_host_oe  = (h_q == H_DATA || h_q == H_TURN);
    bus.irdy_host_n   = ~(h_q == H_DATA);
    bus.ad_host_oe    = (h_q == H_ADDR) || (h_q == H_DATA && wr_q) || (tgt_q && ~bus.irdy_n);
    bus.ad_host       = (h_q == H_ADDR) ? a_q : (h_q == H_DATA) ? w_q : 32'h00000000;
    bus.cbe_host_oe   = (h_q == H_ADDR || h_q == H_DATA);
    bus.cbe_host_n    = (h_q == H_ADDR) ? (wr_q ? `PBC_BUS_CFG_WRITE : `PBC_BUS_CFG_READ)
                                        : 4'h0;
    bus.par_host_oe   = poe_q;
    bus.par_host      = par_q;
    bus.devsel_host_oe = tgt_q;
    bus.devsel_host_n  = ~tgt_q;
    bus.trdy_host_oe   = tgt_q;
    bus.trdy_host_n    = ~tgt_q;
    bus.stop_host_oe   = 1'b0;
    bus.stop_host_n    = 1'b1;
    bus.lock_host_oe   = 1'b0;                                     // host never locks
    bus.lock_host_n    = 1'b1;
  end

  assign cfg_done_o  = dn_q;
  assign cfg_rdata_o = r_q;
  assign perr_seen_o = pe_q;
  assign serr_seen_o = se_q;
endmodule : pbc_host_end

// ### verif/pbc_link_checker.sv
// Concurrent checks on the link between the device end and the host end.
// Assumes link signals are synchronous to clk_i; sits beside the interface instance.
`timescale 1ns/1ns
module pbc_link_checker
  import pbc_pkg::*;
(
  input wire logic      clk_i,
  input wire logic      arst_n_i,
  input wire logic      frame_n,
  input wire logic      irdy_n,
  input wire logic      devsel_n,
  input wire logic      trdy_n,
  input wire logic      stop_n,
  input wire logic      req_n,
  input wire logic      idsel,
  input wire pbc_cmd_t  cbe_n,
  input wire pbc_word_t ad,
  input wire logic      frame_dev_n,
  input wire logic      frame_dev_oe,
  input wire logic      devsel_dev_n,
  input wire logic      devsel_dev_oe,
  input wire logic      ad_dev_oe,
  input wire logic      par_dev,
  input wire logic      par_dev_oe
);
  // One domain, so one clock and one reset for every property
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Device actively framing, device actively claiming
  wire dev_frame = frame_dev_oe & ~frame_dev_n;
  wire dev_claim = devsel_dev_oe & ~devsel_dev_n;
  // Config command seen at address phase
  wire cfg_cmd = (cbe_n == 4'hA) || (cbe_n == 4'hB);

  req_frame_a: assert property ($fell(req_n) |-> ##[1:20] dev_frame)
    else $error("request not followed by device frame");
  frame_req_a: assert property ($rose(dev_frame) |-> $past(!req_n))
    else $error("device framed without a request");
  one_phase_a: assert property (dev_frame |=> frame_dev_oe && frame_dev_n && !irdy_n)
    else $error("frame not released with initiator ready");
  wait_irdy_a: assert property (!irdy_n && trdy_n && stop_n && !devsel_n |=> !irdy_n)
    else $error("initiator ready dropped during wait state");
  phase_end_a: assert property (!irdy_n && (!trdy_n || !stop_n) |=> irdy_n)
    else $error("initiator kept ready after completion or stop");
  no_early_abort_a: assert property ($fell(frame_n) ##1 (devsel_n && trdy_n)[*3]
                                     |-> !irdy_n)
    else $error("initiator aborted too early");
  abort_bound_a: assert property ($fell(frame_n) |-> ##[1:7] irdy_n)
    else $error("unclaimed cycle not ended in time");
  claim_cfg_a: assert property ($fell(frame_n) && idsel && cfg_cmd |=> dev_claim && !trdy_n)
    else $error("configuration cycle not claimed");
  no_claim_a: assert property ($fell(frame_n) && !idsel |=> !dev_claim)
    else $error("device claimed without select");
  trdy_sel_a: assert property (!trdy_n |-> !devsel_n)
    else $error("target ready without device select");
  par_late_a: assert property ($past(ad_dev_oe) && par_dev_oe
                               |-> par_dev == ^{$past(ad), $past(cbe_n)})
    else $error("driven parity wrong");

  // Main scenarios reached
  cfg_cov: cover property ($fell(frame_n) && idsel);
  xfer_cov: cover property (!irdy_n && !trdy_n);
  abort_cov: cover property ($fell(frame_n) ##1 devsel_n[*5]);
endmodule : pbc_link_checker

// ### verif/tb_pci_bus_interface_control.sv
// Self-checking bench: device end and host end joined through the link interface.
// Assumes both ends keep their hand-over contract; one 125 MHz clock domain.
`timescale 1ns/1ns
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_pci_bus_interface_control import pbc_pkg::*;;
  // One row: op 0 cfg write, 1 cfg read, 2 device write, 3 device read
  typedef struct packed {
    logic [1:0] op; pbc_word_t addr; pbc_word_t data; pbc_word_t exp;
  } pbc_row_s;
  logic clk_i = 1'b0, arst_n_i = 1'b0, en_i = 1'b1, go_i = 1'b0, go_lock_i = 1'b0;
  logic pin_mode_i = 1'b0, gpio_out_i = 1'b0, gpio_oe_i = 1'b0, sys_err_i = 1'b0;
  logic sec_par_err_i = 1'b0, bridge_serr_en_i = 1'b0, park_i = 1'b0, cfg_go_i = 1'b0;
  logic cfg_wr_i = 1'b0, claim_i = 1'b1, perr_low = 1'b0;
  pbc_cmd_t  go_cmd_i = 4'h7, go_be_n_i = 4'h0;  // All byte lanes enabled
  pbc_word_t go_addr_i = '0, go_data_i = '0, cfg_addr_i = '0, cfg_data_i = '0;
  pbc_word_t rdata_o, cfg_rdata_o;
  logic      busy_o, done_o, abort_o, stopped_o, gpio_in_o, cfg_done_o, perr_seen_o, serr_seen_o;
  logic [15:0] cmd_reg_o;
  logic      f_done, f_abort, f_lock, f_ev;  // Flags gathered while waiting
  int        errors = 0, num_checks = 0, cyc = 0;
  pbc_row_s  rows [6];

  // 8 ns clock
  always #4 clk_i = ~clk_i;

  pbc_link_if pbc_link_if_i ();
  pbc_dev_end #(.TIMEOUT(5)) pbc_dev_end_i (.clk_i, .arst_n_i, .en_i, .bus(pbc_link_if_i),
    .go_i, .go_cmd_i, .go_addr_i, .go_data_i, .go_be_n_i, .go_lock_i, .pin_mode_i, .gpio_out_i,
    .gpio_oe_i, .sys_err_i, .sec_par_err_i, .bridge_serr_en_i, .busy_o, .done_o, .abort_o,
    .stopped_o, .rdata_o, .cmd_reg_o, .gpio_in_o);
  pbc_host_end pbc_host_end_i (.clk_i, .arst_n_i, .en_i, .bus(pbc_link_if_i), .park_i, .cfg_go_i,
    .cfg_wr_i, .cfg_addr_i, .cfg_data_i, .claim_i, .cfg_done_o, .cfg_rdata_o, .perr_seen_o,
    .serr_seen_o);
  pbc_link_checker pbc_link_checker_i (.clk_i, .arst_n_i, .frame_n(pbc_link_if_i.frame_n),
    .irdy_n(pbc_link_if_i.irdy_n), .devsel_n(pbc_link_if_i.devsel_n),
    .trdy_n(pbc_link_if_i.trdy_n), .stop_n(pbc_link_if_i.stop_n), .req_n(pbc_link_if_i.req_n),
    .idsel(pbc_link_if_i.idsel), .cbe_n(pbc_link_if_i.cbe_n), .ad(pbc_link_if_i.ad),
    .frame_dev_n(pbc_link_if_i.frame_dev_n), .frame_dev_oe(pbc_link_if_i.frame_dev_oe),
    .devsel_dev_n(pbc_link_if_i.devsel_dev_n), .devsel_dev_oe(pbc_link_if_i.devsel_dev_oe),
    .ad_dev_oe(pbc_link_if_i.ad_dev_oe), .par_dev(pbc_link_if_i.par_dev),
    .par_dev_oe(pbc_link_if_i.par_dev_oe));

  // Verdict and end of run, also reached from the hang limit
  task automatic print_verdict();
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // Wait n edges, then move 1 ns past the last so inputs never race the edge
  task automatic step(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step

  // One transfer from either end; bounded wait for its completion pulse
  task automatic run(logic [1:0] op, pbc_word_t a, pbc_word_t d, logic lk);
    int k;
    {cfg_wr_i, go_cmd_i, go_lock_i} = {~op[0], op[0] ? 4'h6 : 4'h7, lk};
    {cfg_addr_i, cfg_data_i, go_addr_i, go_data_i} = {a, d, a, d};
    {cfg_go_i, go_i} = {~op[1], op[1]};
    step(1);
    {cfg_go_i, go_i, f_done, f_abort, f_lock} = 5'h00;
    k = 0;
    while (k < 40 && !f_done && !f_abort) begin
      f_done = op[1] ? done_o === 1'b1 : cfg_done_o === 1'b1;
      f_abort = abort_o === 1'b1 || stopped_o === 1'b1;
      f_lock |= pbc_link_if_i.lock_n === 1'b0;
      step(1);
      k++;
    end
    step(2);  // Turnaround before the next request
  endtask : run

  // Pulse an error event and watch the system error line for four clocks
  task automatic ev(logic s, logic b);
    {sys_err_i, sec_par_err_i, f_ev} = {s, b, 1'b0};
    step(1);
    {sys_err_i, sec_par_err_i} = 2'b00;
    repeat (4) begin
      f_ev |= pbc_link_if_i.serr_n === 1'b0;
      step(1);
    end
  endtask : ev

  // Hang limit, far above the hundred-odd clocks the sequence needs; parity error watch
  always @(posedge clk_i) begin
    cyc++;
    if (pbc_link_if_i.perr_n === 1'b0) perr_low = 1'b1;
    if (cyc == 3000) begin
      errors++;
      print_verdict();
    end
  end

  initial begin
    rows = '{'{2'd0, 32'h0000_0004, 32'h0000_0000, 32'h0000_0000},
             '{2'd1, 32'h0000_0004, 32'h0000_0000, 32'h0000_0000},
             '{2'd2, 32'h1000_0000, 32'hA5A5_5A5A, 32'h0000_0000},
             '{2'd3, 32'h1000_0004, 32'h0000_0000, 32'h0000_0000},
             '{2'd0, 32'h0000_0004, 32'h0000_0140, 32'h0000_0140},
             '{2'd1, 32'h0000_0004, 32'h0000_0000, 32'h0000_0140}};
    step(6);
    arst_n_i = 1'b1;
    `CHK(gpio_in_o, 1'b1)
    foreach (rows[i]) begin
      run(rows[i].op, rows[i].addr, rows[i].data, 1'b0);
      `CHK(f_done, 1'b1)
      case (rows[i].op)
        2'd0: `CHK({16'h0000, cmd_reg_o}, rows[i].exp)
        2'd1: `CHK(cfg_rdata_o, rows[i].exp)
        2'd3: `CHK(rdata_o, rows[i].exp)
        default: `CHK(f_abort, 1'b0)
      endcase
    end
    // Reporting now on: internal error always, secondary one only with bridge enable
    ev(1'b1, 1'b0);
    `CHK(f_ev, 1'b1)
    ev(1'b0, 1'b1);
    `CHK(f_ev, 1'b0)
    bridge_serr_en_i = 1'b1;
    ev(1'b0, 1'b1);
    `CHK(f_ev, 1'b1)
    // Nobody claims: initiator must abort, not complete
    claim_i = 1'b0;
    run(2'd2, 32'h2000_0000, 32'h1234_5678, 1'b0);
    `CHK({f_done, f_abort}, 2'b01)
    claim_i = 1'b1;
    // Parked grant with nothing to do must stay quiet, then serve a transfer
    park_i = 1'b1;
    f_ev = 1'b0;
    repeat (20) begin
      step(1);
      f_ev |= pbc_link_if_i.frame_n === 1'b0 || busy_o === 1'b1;
    end
    `CHK(f_ev, 1'b0)
    run(2'd3, 32'h1000_0008, 32'h0000_0000, 1'b0);
    `CHK(f_done, 1'b1)
    park_i = 1'b0;
    // Shared pin as general output, then as lock
    gpio_oe_i = 1'b1;
    step(2);
    `CHK(gpio_in_o, 1'b0)
    gpio_oe_i = 1'b0;
    pin_mode_i = 1'b1;
    run(2'd2, 32'h1000_000C, 32'h0F0F_F0F0, 1'b1);
    `CHK({f_done, f_lock}, 2'b11)
    pin_mode_i = 1'b0;
    // Reset between transfers, device idle: command word cleared, request and lock released
    arst_n_i = 1'b0;
    step(2);
    `CHK(cmd_reg_o, 16'h0000)
    `CHK({pbc_link_if_i.req_n, pbc_link_if_i.lock_dev_oe}, 2'b10)
    arst_n_i = 1'b1;
    step(1);
    ev(1'b1, 1'b0);
    `CHK(f_ev, 1'b0)
    `CHK(perr_low, 1'b0)
    `CHK(perr_seen_o, 1'b0)
    print_verdict();
  end
endmodule : tb_pci_bus_interface_control
